// File: design/eio_map.vh
`ifndef EIO_MAP_VH
`define EIO_MAP_VH
// register byte offsets
`define EIO_CTRL_OFS 12'h000
`define EIO_ASGN_OFS 12'h004
`define EIO_SER_OFS 12'h008
`define EIO_STAT_OFS 12'h00c
`define EIO_CYC_OFS 12'h010
// control register fields
`define EIO_C_HOLD 0
`define EIO_C_VOLT 1
`define EIO_C_CLMP_LO 2
`define EIO_C_CLMP_HI 4
`define EIO_C_POL_LO 5
`define EIO_C_POL_HI 8
`define EIO_C_DIG 9
`define EIO_C_MODE_LO 10
`define EIO_C_MODE_HI 11
`define EIO_CTRL_W 12
`define EIO_CTRL_RST 12'h1ec
// serial register fields
`define EIO_S_W 15
`define EIO_S_NODE_LO 10
`define EIO_S_NODE_HI 14
`define EIO_SER_RST 15'h0020
`define EIO_NODE_MAX 5'h10
// clamp selections
`define EIO_CL_LOW 3'h0
`define EIO_CL_MID 3'h1
`define EIO_CL_HIGH 3'h2
`define EIO_CL_MAX 3'h3
`define EIO_CL_MIN 3'h4
// measurement modes
`define EIO_MODE_HIGH 2'h2
`define EIO_MODE_CUSTOM 2'h3
// clamp levels: current in microamps, voltage in signed millivolts
`define EIO_I_4MA 16'h0fa0
`define EIO_I_12MA 16'h2ee0
`define EIO_I_20MA 16'h4e20
`define EIO_I_MAX 16'h61a8
`define EIO_I_MIN 16'h07d0
`define EIO_V_N10 16'hd8f0
`define EIO_V_0 16'h0000
`define EIO_V_P10 16'h2710
`define EIO_V_MAX 16'h2af8
`define EIO_V_MIN 16'hd508
// timing
`define EIO_CLK_HZ 20000000
`define EIO_BANK_DLY_MS 500
`define EIO_BANK_MAX_S 30
`define EIO_CYC_RST 16'h0064
`endif

// File: design/eio_bank_io.v
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "eio_map.vh"
// Function
// - hold mode keeps last judgment and linear
// - clamp mode: judgments off, linear clamp value
// - current clamp choices 4/12/20/max/min mA
// - voltage clamp choices -10/0/10/max/min V
// - before first hold value, behave as clamp
// - per-wire polarity for four inputs
// - standard pattern: trigger, reset, laser-off, zero
// - bank pattern: wires 0,1 select bank
// - A,B encode bank 1 to 4
// - bank switch starts 0.5 s after change
// - bank switch completes within 30 s
// - busy high during whole bank switch
// - assignment pattern stored per bank
// - digital output gates batch stream command
// - high/custom modes with digital output on: cycle times 1.5
// - other modes: cycle unchanged
// - selecting high mode clears digital output
// - monitor graph/logging forces digital output on
// - serial 7/8 bits, parity, 1/2 stop
// - baud 9600 to 115200, default 38400
// - terminator CR, LF or CR+LF
// - node 0..16 and protocol selection
module eio_bank_io #(
   parameter BANK_DLY_CYC = `EIO_CLK_HZ / 1000 * `EIO_BANK_DLY_MS,
   parameter SWITCH_CYC = `EIO_CLK_HZ * `EIO_BANK_MAX_S,
   parameter LIN_W = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire input_wire_0,
   input wire input_wire_1,
   input wire input_wire_2,
   input wire input_wire_3,
   input wire meas_valid,
   input wire hold_meas,
   input wire [2:0] judge_in,
   input wire [LIN_W-1:0] linear_in,
   input wire monitor_active,
   input wire batch_stream_command,
   output reg [2:0] judge_out,
   output reg [LIN_W-1:0] linear_out,
   output reg trigger_active,
   output reg reset_active,
   output reg laser_off_input,
   output reg zero_reset_active,
   output reg [1:0] bank_sel,
   output reg busy,
   output reg batch_accept,
   output reg batch_reject,
   output reg [15:0] meas_cycle,
   output wire [`EIO_S_W-1:0] serial_cfg
);

   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   // idle: bank inputs match the live bank, or standard pattern
   // wait: a new select pattern is settling, counted in pclk cycles
   // switch: busy is high while the new bank loads
   // the fourth code is unused and falls back to idle
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_SWITCH = 2'h2;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // ctrl_q: hold/clamp, scale, clamp choice, polarity, digital, mode
   // asgn_q: one pattern bit per bank, so each bank keeps its own
   // ser_q: framing, rate, terminator, protocol and node number
   // cyc_base_q: cycle before any digital-output stretch
   // cnt_q is shared by the settle delay and the switch span; it is
   // 32 bits so the full-scale switch time still fits
   reg [`EIO_CTRL_W-1:0] ctrl_q;
   reg [3:0] asgn_q;
   reg [`EIO_S_W-1:0] ser_q;
   reg [15:0] cyc_base_q;
   reg [1:0] state_q;
   reg [31:0] cnt_q;
   reg [1:0] sel_seen_q;
   reg have_val_q;
   reg [2:0] judge_last_q;
   reg [LIN_W-1:0] lin_last_q;
   wire [3:0] act;
   wire [1:0] sel_now;
   wire bank_pat;
   wire dig_eff;
   wire use_hold;
   wire wr;
   wire rd_hit;
   wire [2:0] clsel;
   wire [1:0] mode;
   reg [LIN_W-1:0] clamp_val;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // a wire is active when its level equals its polarity bit;
   // polarity 1 means active while the wire is on, 0 while it is off
   // the same test is used for all four wires, hence a function
   function act_of;
      input lvl;
      input pol;
      begin
         act_of = ~(lvl ^ pol);
      end
   endfunction

   // high and custom modes have the short cycle that digital output
   // stretches; every other mode keeps its cycle
   function is_fast;
      input [1:0] m;
      begin
         is_fast = (m == `EIO_MODE_HIGH) || (m == `EIO_MODE_CUSTOM);
      end
   endfunction

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   // zero wait states; the cost is a wide read mux on the access cycle
   // writes land on the access edge; an unmapped address answers
   // with pslverr and is ignored, status is read-only and drops
   // writes, and a write to the cycle address sets the base cycle
   assign pready = 1'b1;
   assign wr = psel & penable & pwrite;
   assign rd_hit = (paddr == `EIO_CTRL_OFS) || (paddr == `EIO_ASGN_OFS) ||
      (paddr == `EIO_SER_OFS) || (paddr == `EIO_STAT_OFS) ||
      (paddr == `EIO_CYC_OFS);
   assign pslverr = psel & penable & ~rd_hit;
   assign mode = ctrl_q[`EIO_C_MODE_HI:`EIO_C_MODE_LO];
   assign clsel = ctrl_q[`EIO_C_CLMP_HI:`EIO_C_CLMP_LO];
   assign serial_cfg = ser_q;

   // register writes
   // a write to the control word that selects high mode drops the
   // digital bit in the same edge, so no stretched cycle is seen unless monitor use forces digital output on
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `EIO_CTRL_RST;
         asgn_q <= 4'h0;
         ser_q <= `EIO_SER_RST;
         cyc_base_q <= `EIO_CYC_RST;
      end else if (wr) begin
         case (paddr)
            `EIO_CTRL_OFS: begin
               ctrl_q <= pwdata[`EIO_CTRL_W-1:0];
               // high mode runs at the unstretched cycle unless monitor use forces digital output on
               if (pwdata[`EIO_C_MODE_HI:`EIO_C_MODE_LO] == `EIO_MODE_HIGH)
                  ctrl_q[`EIO_C_DIG] <= 1'b0;
            end
            `EIO_ASGN_OFS: asgn_q <= pwdata[3:0];
            `EIO_SER_OFS: begin
               // an out-of-range node number is ignored whole
               if (pwdata[`EIO_S_NODE_HI:`EIO_S_NODE_LO] <= `EIO_NODE_MAX)
                  ser_q <= pwdata[`EIO_S_W-1:0];
            end
            `EIO_CYC_OFS: cyc_base_q <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // read mux
   // pure decode of the address, valid in setup and access phases
   always @* begin
      prdata = 32'h0000_0000;
      case (paddr)
         `EIO_CTRL_OFS: prdata[`EIO_CTRL_W-1:0] = ctrl_q;
         `EIO_ASGN_OFS: prdata[3:0] = asgn_q;
         `EIO_SER_OFS: prdata[`EIO_S_W-1:0] = ser_q;
         `EIO_STAT_OFS: prdata[5:0] = {dig_eff, have_val_q, busy,
            state_q == ST_WAIT, bank_sel};
         `EIO_CYC_OFS: prdata = {cyc_base_q, meas_cycle};
         default: prdata = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------
   // input decode
   // ------------------------------------------------------------
   assign act[0] = act_of(input_wire_0, ctrl_q[`EIO_C_POL_LO]);
   assign act[1] = act_of(input_wire_1, ctrl_q[`EIO_C_POL_LO+1]);
   assign act[2] = act_of(input_wire_2, ctrl_q[`EIO_C_POL_LO+2]);
   assign act[3] = act_of(input_wire_3, ctrl_q[`EIO_C_POL_LO+3]);
   assign bank_pat = asgn_q[bank_sel];
   // a is the high bit: off,on selects the second bank
   assign sel_now = {act[0], act[1]};

   // function outputs registered, one cycle behind the wires
   // in bank pattern wires 0 and 1 are select bits, so trigger and
   // reset stay off there; laser-off and zero reset work in both
   // patterns
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_active <= 1'b0;
         reset_active <= 1'b0;
         laser_off_input <= 1'b0;
         zero_reset_active <= 1'b0;
      end else begin
         trigger_active <= act[0] & ~bank_pat;
         reset_active <= act[1] & ~bank_pat;
         laser_off_input <= act[2];
         zero_reset_active <= act[3];
      end
   end

   // ------------------------------------------------------------
   // bank switch sequencer
   // ------------------------------------------------------------
   // any further change while waiting restarts the settle delay
   // leaving bank pattern while waiting abandons the switch; once
   // busy is up the switch always runs to its end, since a half-loaded
   // bank is worse than a late one
   // limitation: the switch always takes the full maximum span
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         cnt_q <= 32'h0000_0000;
         sel_seen_q <= 2'h0;
         bank_sel <= 2'h0;
         busy <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (bank_pat && sel_now != bank_sel) begin
                  state_q <= ST_WAIT;
                  sel_seen_q <= sel_now;
                  cnt_q <= 32'h0000_0000;
               end
            end
            ST_WAIT: begin
               if (!bank_pat) begin
                  state_q <= ST_IDLE;
               end else if (sel_now != sel_seen_q) begin
                  sel_seen_q <= sel_now;
                  cnt_q <= 32'h0000_0000;
               end else if (cnt_q == BANK_DLY_CYC - 1) begin
                  state_q <= ST_SWITCH;
                  cnt_q <= 32'h0000_0000;
                  busy <= 1'b1;
               end else begin
                  cnt_q <= cnt_q + 32'h0000_0001;
               end
            end
            ST_SWITCH: begin
               // new bank goes live as busy falls
               if (cnt_q == SWITCH_CYC - 1) begin
                  state_q <= ST_IDLE;
                  bank_sel <= sel_seen_q;
                  busy <= 1'b0;
               end else begin
                  cnt_q <= cnt_q + 32'h0000_0001;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // no-measurement handling
   // ------------------------------------------------------------
   // clamp level table, current or voltage scale
   // current levels in microamps, voltage levels in signed millivolts
   // unused choices fall to the maximum, the safe default
   always @* begin
      case (clsel)
         `EIO_CL_LOW: clamp_val = ctrl_q[`EIO_C_VOLT] ? `EIO_V_N10 :
            `EIO_I_4MA;
         `EIO_CL_MID: clamp_val = ctrl_q[`EIO_C_VOLT] ? `EIO_V_0 :
            `EIO_I_12MA;
         `EIO_CL_HIGH: clamp_val = ctrl_q[`EIO_C_VOLT] ? `EIO_V_P10 :
            `EIO_I_20MA;
         `EIO_CL_MIN: clamp_val = ctrl_q[`EIO_C_VOLT] ? `EIO_V_MIN :
            `EIO_I_MIN;
         default: clamp_val = ctrl_q[`EIO_C_VOLT] ? `EIO_V_MAX :
            `EIO_I_MAX;
      endcase
   end

   // hold needs a captured value; in hold measurement none exists at first
   assign use_hold = ctrl_q[`EIO_C_HOLD] & (have_val_q | ~hold_meas);

   // a fresh value always passes straight through and is remembered
   // for hold; without one, hold or clamp decides the outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         have_val_q <= 1'b0;
         judge_last_q <= 3'h0;
         lin_last_q <= {LIN_W{1'b0}};
         judge_out <= 3'h0;
         linear_out <= {LIN_W{1'b0}};
      end else begin
         if (meas_valid) begin
            have_val_q <= 1'b1;
            judge_last_q <= judge_in;
            lin_last_q <= linear_in;
            judge_out <= judge_in;
            linear_out <= linear_in;
         end else if (use_hold) begin
            judge_out <= judge_last_q;
            linear_out <= lin_last_q;
         end else begin
            judge_out <= 3'h0;
            linear_out <= clamp_val;
         end
      end
   end

   // ------------------------------------------------------------
   // digital output and measurement cycle
   // ------------------------------------------------------------
   // monitor use forces digital output on, even in high mode
   assign dig_eff = ctrl_q[`EIO_C_DIG] | monitor_active;

   // batch answers last as long as the request, one edge after it;
   // the stretched cycle is base plus half base, rounded down

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         batch_accept <= 1'b0;
         batch_reject <= 1'b0;
         meas_cycle <= `EIO_CYC_RST;
      end else begin
         batch_accept <= batch_stream_command & dig_eff;
         batch_reject <= batch_stream_command & ~dig_eff;
         if (dig_eff && is_fast(mode))
            meas_cycle <= cyc_base_q + {1'b0, cyc_base_q[15:1]};
         else
            meas_cycle <= cyc_base_q;
      end
   end

endmodule // eio_bank_io

// File: tb/eio_props.sv
`timescale 1ns/1ps
module eio_props #(
   parameter int SWITCH_CYC = 30
) (
   input wire pclk,
   input wire presetn,
   input wire pready,
   input wire input_wire_0,
   input wire input_wire_1,
   input wire meas_valid,
   input wire [2:0] judge_in,
   input wire [2:0] judge_out,
   input wire batch_stream_command,
   input wire batch_accept,
   input wire batch_reject,
   input wire [1:0] bank_sel,
   input wire busy
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // zero wait state slave, so the master never stalls
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_busy_span: assert property ($rose(busy) |-> busy [*8])
      else $error("busy too short");
   a_busy_end: assert property (busy |-> ##[1:SWITCH_CYC] !busy)
      else $error("switch too long");
   a_bank_move: assert property (!$stable(bank_sel) |-> $fell(busy))
      else $error("bank moved outside switch end");
   a_bank_wait: assert property ($rose(busy) |->
      $stable({input_wire_0, input_wire_1}))
      else $error("switch began on unsettled select");
   a_batch_ans: assert property (batch_stream_command |=>
      batch_accept != batch_reject)
      else $error("batch not answered once");
   a_batch_quiet: assert property (!batch_stream_command |=>
      !batch_accept && !batch_reject)
      else $error("stray batch answer");
   a_meas_follow: assert property (meas_valid |=>
      judge_out == $past(judge_in))
      else $error("judgment not passed through");
endmodule // eio_props

bind eio_bank_io eio_props #(.SWITCH_CYC(SWITCH_CYC)) i_eio_props (
   .pclk, .presetn, .pready, .input_wire_0, .input_wire_1, .meas_valid,
   .judge_in, .judge_out, .batch_stream_command, .batch_accept,
   .batch_reject, .bank_sel, .busy);

// File: tb/eio_host.sv
`timescale 1ns/1ps
module eio_host (
   input wire pclk,
   input wire [3:0] act,
   input wire [3:0] pol,
   output logic [3:0] wire_q
);
   // the host only moves its wires just after an edge
   always @(posedge pclk) begin
      wire_q <= ~(act ^ pol);
   end
endmodule // eio_host

// File: tb/external_io_bank_select_bench.sv
`timescale 1ns/1ps
`include "eio_map.vh"
module external_io_bank_select_bench;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, busy, batch_accept, batch_reject;
   logic meas_valid = 0;
   logic hold_meas = 0;
   logic monitor_active = 0;
   logic batch_stream_command = 0;
   logic [2:0] judge_in = 0;
   logic [15:0] linear_in = 0;
   logic [3:0] act = 0;
   logic [3:0] pol = 4'hf;
   logic [3:0] wq;
   logic [2:0] judge_out;
   logic [15:0] linear_out, meas_cycle;
   logic trigger_active, reset_active, laser_off_input, zero_reset_active;
   logic [1:0] bank_sel;
   logic [14:0] serial_cfg;
   logic [15:0] lv [0:9] = '{`EIO_I_4MA, `EIO_I_12MA, `EIO_I_20MA,
      `EIO_I_MAX, `EIO_I_MIN, `EIO_V_N10, `EIO_V_0, `EIO_V_P10,
      `EIO_V_MAX, `EIO_V_MIN};
   int n_fail = 0;
   int comparisons = 0;
   int n;

   eio_bank_io #(.BANK_DLY_CYC(20), .SWITCH_CYC(30)) i_eio_bank_io (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .input_wire_0(wq[0]), .input_wire_1(wq[1]),
      .input_wire_2(wq[2]), .input_wire_3(wq[3]), .meas_valid, .hold_meas,
      .judge_in, .linear_in, .monitor_active, .batch_stream_command,
      .judge_out, .linear_out, .trigger_active, .reset_active,
      .laser_off_input, .zero_reset_active, .bank_sel, .busy,
      .batch_accept, .batch_reject, .meas_cycle, .serial_cfg);
   eio_host i_eio_host (.pclk, .act, .pol, .wire_q(wq));

   always #25 pclk = ~pclk;

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   // sample a little after the edge so its updates have landed
   task stepc(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask
   task pulse(input logic ok);
      @(posedge pclk);
      batch_stream_command <= 1'b1;
      @(posedge pclk);
      batch_stream_command <= 1'b0;
      #1;
      chk({batch_accept, batch_reject}, {ok, ~ok}, "batch answer");
   endtask
   task finish_test;
      $display("fails %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset;
      stepc(2);
      chk(linear_out, `EIO_I_MAX, "default clamp");
      apb(`EIO_SER_OFS, 1'b0, 0);
      chk(rd, 32'h2 << 4, "serial default");
      apb(`EIO_CYC_OFS, 1'b0, 0);
      chk(rd, 32'h00640064, "cycle default");
      $display("reset test done");
   endtask
   // have-value never clears, so this must come before any measurement
   task t_hold;
      apb(`EIO_CTRL_OFS, 1'b1, 32'h1e1);
      @(posedge pclk);
      hold_meas <= 1'b1;
      stepc(3);
      chk(linear_out, `EIO_I_4MA, "hold before first value");
      @(posedge pclk);
      meas_valid <= 1'b1;
      judge_in <= 3'h5;
      linear_in <= 16'h1234;
      @(posedge pclk);
      meas_valid <= 1'b0;
      judge_in <= 3'h2;
      linear_in <= 16'h0000;
      hold_meas <= 1'b0;
      stepc(3);
      chk({judge_out, linear_out}, {3'h5, 16'h1234}, "held");
      $display("hold test done");
   endtask
   task t_clamp;
      for (int i = 0; i < 10; i++) begin
         apb(`EIO_CTRL_OFS, 1'b1,
            32'h1e0 | 32'(i / 5) << 1 | 32'(i % 5) << 2);
         stepc(2);
         chk({judge_out, linear_out}, {3'h0, lv[i]}, "clamp");
      end
      $display("clamp test done");
   endtask
   task t_wires;
      for (int p = 0; p < 2; p++) begin
         apb(`EIO_CTRL_OFS, 1'b1, p ? 32'h1e0 : 32'h000);
         @(posedge pclk);
         pol <= {4{p[0]}};
         act <= 4'b0101;
         stepc(4);
         chk({trigger_active, reset_active, laser_off_input,
            zero_reset_active}, 4'b1010, "standard map");
      end
      $display("wire test done");
   endtask
   task t_serial;
      apb(`EIO_SER_OFS, 1'b1, 32'h4020);
      apb(`EIO_SER_OFS, 1'b1, 32'h4420);
      apb(`EIO_SER_OFS, 1'b0, 0);
      chk(rd, 32'h4020, "node limit");
      chk(serial_cfg, 15'h4020, "serial cfg pins");
      apb(12'h014, 1'b0, 0);
      chk({er, rd}, {1'b1, 32'h0}, "unmapped read");
      $display("serial test done");
   endtask
   task t_batch;
      apb(`EIO_CTRL_OFS, 1'b1, 32'h7f0);
      stepc(2);
      chk(meas_cycle, 16'h0064, "plain mode cycle");
      pulse(1'b1);
      apb(`EIO_CTRL_OFS, 1'b1, 32'hff0);
      stepc(2);
      chk(meas_cycle, 16'h0096, "custom mode cycle");
      apb(`EIO_CTRL_OFS, 1'b1, 32'hbf0);
      apb(`EIO_CTRL_OFS, 1'b0, 0);
      chk(rd, 32'h9f0, "high mode clears digital");
      chk(meas_cycle, 16'h0064, "high mode cycle");
      pulse(1'b0);
      @(posedge pclk);
      monitor_active <= 1'b1;
      stepc(3);
      chk(meas_cycle, 16'h0096, "monitor cycle");
      pulse(1'b1);
      $display("batch test done");
   endtask
   task t_bank;
      apb(`EIO_CTRL_OFS, 1'b1, 32'h1e0);
      apb(`EIO_ASGN_OFS, 1'b1, 32'h1);
      @(posedge pclk);
      pol <= 4'hf;
      act <= 4'b0001;
      n = 0;
      while (busy !== 1'b1 && n < 100) begin
         stepc(1);
         n++;
      end
      chk(n >= 20, 1, "switch too early");
      chk(trigger_active, 0, "select bit acted as trigger");
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         chk(bank_sel, 2'd0, "bank moved early");
         stepc(1);
         n++;
      end
      chk({n[7:0], bank_sel}, {8'd30, 2'd2}, "bank three");
      @(posedge pclk);
      act <= 4'b0000;
      stepc(4);
      chk({trigger_active, busy}, 2'b00, "bank three idle");
      @(posedge pclk);
      act <= 4'b0001;
      stepc(4);
      chk({trigger_active, busy}, 2'b10, "bank three standard");
      $display("bank test done");
   endtask

   initial begin
      #2000000;
      n_fail++;
      finish_test;
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_hold;
      t_clamp;
      t_wires;
      t_serial;
      t_batch;
      t_bank;
      finish_test;
   end
endmodule // external_io_bank_select_bench
